//--- tsnw_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsnw_ctrl_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        wr_req_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic [2:0]  wr_area_i,
	input  wire logic [1:0]  dly_i,
	output logic             wr_ack_o,
	output logic [15:0]      word_o,
	output logic [2:0]       area_o,
	output logic [15:0]      cnt_o,
	output logic             bad_o
);
	logic [1:0] wait_reg;

	// Takes each word after dly_i cycles, so prompt and slow answers both occur.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_ack_o <= 1'b0;
			wait_reg <= 2'h0;
			word_o   <= 16'h0000;
			area_o   <= 3'h0;
			cnt_o    <= 16'h0000;
			bad_o    <= 1'b0;
		end else begin
			wr_ack_o <= 1'b0;
			if (wr_req_i && !wr_ack_o) begin
				if (wait_reg == dly_i) begin
					wr_ack_o <= 1'b1;
					wait_reg <= 2'h0;
					word_o   <= wr_data_i;
					area_o   <= wr_area_i;
					cnt_o    <= cnt_o + 16'h0001;
					bad_o    <= bad_o | (wr_area_i > 3'h4);
				end else begin
					wait_reg <= wait_reg + 2'h1;
				end
			end
		end
	end
endmodule // tsnw_ctrl_model
`default_nettype wire

//--- tsnw_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries the send handshake and password events between the top and its helpers.
interface tsnw_link_if;
	logic                 send_req;
	logic [15:0]          send_word;
	tsnw_pkg::tsnw_area_t send_area;
	logic                 busy;
	logic                 done;
	logic [15:0]          done_word;
	logic                 wr_req;
	tsnw_pkg::tsnw_area_t wr_area;
	logic                 pwd_attempt;
	logic                 pwd_match;
	logic                 pwd_reset;
	logic                 pwd_fail;

	modport top (output send_req, send_word, send_area, pwd_attempt, pwd_match, pwd_reset,
		input busy, done, done_word, wr_req, wr_area, pwd_fail);
	modport tx (input send_req, send_word, send_area,
		output busy, done, done_word, wr_req, wr_area);
	modport pwd (input pwd_attempt, pwd_match, pwd_reset, output pwd_fail);
endinterface
`default_nettype wire

//--- tsnw_pkg.sv
package tsnw_pkg;

	// Controller memory area that holds the status word.
	typedef enum logic [2:0] {
		TSNW_AREA_DATA_MEMORY    = 3'b000,
		TSNW_AREA_INTERNAL_RELAY = 3'b001,
		TSNW_AREA_HOLDING_RELAY  = 3'b010,
		TSNW_AREA_AUX_RELAY      = 3'b011,
		TSNW_AREA_LINK_RELAY     = 3'b100,
		TSNW_AREA_TIMER          = 3'b101,
		TSNW_AREA_COUNTER        = 3'b110,
		TSNW_AREA_UNUSED         = 3'b111
	} tsnw_area_t;

	// Write engine states.
	typedef enum logic [0:0] {
		TSNW_TX_IDLE = 1'b0,
		TSNW_TX_WAIT = 1'b1
	} tsnw_tx_state_t;

	typedef struct packed {
		tsnw_tx_state_t state;
		logic           wr_req;
		logic [15:0]    wr_data;
		tsnw_area_t     wr_area;
		logic           done;
	} tsnw_tx_reg_t;

	typedef struct packed {
		logic [1:0] fail_cnt;
		logic       fail;
	} tsnw_pwd_reg_t;

	typedef struct packed {
		logic        run_ind;
		logic        scr_evt;
		logic        val_evt;
		logic        pwd_evt;
		logic [15:0] last_word;
		logic        sent_once;
		logic        send_req;
		logic        enable;
		tsnw_area_t  area;
		logic [3:0]  irq_stat;
		logic [3:0]  irq_mask;
		logic [15:0] report_cnt;
		logic [31:0] rd_data;
		logic        irq;
	} tsnw_top_reg_t;

endpackage

//--- tsnw_props.sv
`timescale 1ns/1ps
`default_nettype none
module tsnw_props (
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        mode_run_i,
	input wire logic        sysmenu_shown_i,
	input wire logic        screen_changed_i,
	input wire logic        value_stored_i,
	input wire logic        wr_req_o,
	input wire logic [15:0] wr_data_o,
	input wire logic [2:0]  wr_area_o,
	input wire logic        wr_ack_i,
	input wire logic        run_ind_o
);
	logic run_ok;

	// Running means normal mode with the menu off.
	assign run_ok = mode_run_i && !sysmenu_shown_i;
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// A request stands until it is taken, and the next one waits two cycles.
	a_req_hold: assert property (
		wr_req_o && !wr_ack_i |=> wr_req_o && $stable(wr_data_o) && $stable(wr_area_o))
		else $error("write request changed before ack");
	a_ack_gap: assert property (wr_req_o && wr_ack_i |=> !wr_req_o [*2])
		else $error("write request too soon after ack");
	a_spare_zero: assert property (
		wr_req_o |-> (wr_data_o & 16'h65FF) == 16'h0000)
		else $error("unused status bit set");
	// Run state, and silence once the stop has been reported.
	a_run_follow: assert property (
		$past(rst_n_i) |-> run_ind_o == $past(run_ok))
		else $error("run indicator does not follow mode");
	a_stop_quiet: assert property (
		(wr_req_o && wr_ack_i && !wr_data_o[15] && !run_ind_o) ##1 !run_ind_o [*4]
		|-> !wr_req_o)
		else $error("write issued while stopped");
	// Screen and value events are reported within a bounded time, and the screen event is then cleared.
	a_screen_sent: assert property (
		screen_changed_i && run_ind_o && run_ok |-> ##[2:40] wr_req_o && wr_data_o[12])
		else $error("screen change not reported");
	a_value_sent: assert property (
		value_stored_i && run_ind_o && run_ok |-> ##[2:40] wr_req_o && wr_data_o[11])
		else $error("value entry not reported");
	a_event_clear: assert property (
		(wr_req_o && wr_ack_i && wr_data_o[12] && !screen_changed_i)
		##1 !screen_changed_i [*2] |=> ##1 wr_req_o && !wr_data_o[12])
		else $error("screen event not cleared after report");
endmodule // tsnw_props

bind tsnw_top tsnw_props chk_u (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.mode_run_i(mode_run_i),
	.sysmenu_shown_i(sysmenu_shown_i),
	.screen_changed_i(screen_changed_i),
	.value_stored_i(value_stored_i),
	.wr_req_o(wr_req_o),
	.wr_data_o(wr_data_o),
	.wr_area_o(wr_area_o),
	.wr_ack_i(wr_ack_i),
	.run_ind_o(run_ind_o)
);
`default_nettype wire

//--- tsnw_pwd_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsnw_regs.svh"
module tsnw_pwd_check (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	tsnw_link_if.pwd  link
);
	tsnw_pkg::tsnw_pwd_reg_t cur_reg;
	tsnw_pkg::tsnw_pwd_reg_t cur_next;

	// A match breaks the run of mismatches; the third mismatch in a row fires one pulse.
	always_comb begin
		cur_next      = cur_reg;
		cur_next.fail = 1'b0;
		if (link.pwd_reset) begin
			cur_next.fail_cnt = 2'h0;
		end else if (link.pwd_attempt) begin
			if (link.pwd_match) begin
				cur_next.fail_cnt = 2'h0;
			end else if (cur_reg.fail_cnt == (`TSNW_PWD_FAIL_LIMIT - 2'h1)) begin
				cur_next.fail_cnt = 2'h0;
				cur_next.fail     = 1'b1;
			end else begin
				cur_next.fail_cnt = cur_reg.fail_cnt + 2'h1;
			end
		end
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign link.pwd_fail = cur_reg.fail;
endmodule // tsnw_pwd_check
`default_nettype wire

//--- tsnw_regs.svh
// Function
// - Run indicator bit is one only in normal running mode, zero otherwise or in menu.
// - While run indicator is zero, no controller memory bits or words are accessed; the code still sends the one write that carries the falling run bit.
// - Screen change strobe bit sets whenever the displayed screen changes, from any source.
// - Value entry strobe bit sets after an operator stores a numeric table value.
// - Password failure bit sets after three consecutive mismatching password entries; the code resets the count and skips entries while run indicator is zero.
// - Each event bit returns to zero once its set state was reported.
// - Status word is written to the controller whenever any reported status changes.
`ifndef TSNW_REGS_SVH
`define TSNW_REGS_SVH

// Status word layout.
`define TSNW_WORD_W          16
`define TSNW_BIT_RUN         15
`define TSNW_BIT_SCREEN      12
`define TSNW_BIT_VALUE       11
`define TSNW_BIT_PASSWORD    9

// Register bus.
`define TSNW_ADDR_W          8
`define TSNW_DATA_W          32
`define TSNW_OFS_STATUS_WORD 8'h00
`define TSNW_OFS_CTRL        8'h04
`define TSNW_OFS_IRQ_STATUS  8'h08
`define TSNW_OFS_IRQ_MASK    8'h0C
`define TSNW_OFS_REPORT_CNT  8'h10

// Control register fields and reset values.
`define TSNW_CTRL_ENABLE     0
`define TSNW_CTRL_AREA_LSB   1
`define TSNW_CTRL_AREA_MSB   3
`define TSNW_RST_ENABLE      1'h1
`define TSNW_RST_IRQ_MASK    4'h0

// Interrupt status bits.
`define TSNW_IRQ_W           4
`define TSNW_IRQ_REPORTED    0
`define TSNW_IRQ_PWD_FAIL    1
`define TSNW_IRQ_AREA_ERR    2
`define TSNW_IRQ_RUN_CHANGE  3

// Consecutive mismatching password entries that raise the failure bit.
`define TSNW_PWD_FAIL_LIMIT  2'h3

`endif

//--- tsnw_report_tx.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsnw_regs.svh"
module tsnw_report_tx (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic wr_ack_i,
	output logic [15:0] wr_data_o,
	tsnw_link_if.tx   link
);
	tsnw_pkg::tsnw_tx_reg_t cur_reg;
	tsnw_pkg::tsnw_tx_reg_t cur_next;

	// Holds one word on the write port until the controller acknowledges it.
	always_comb begin
		cur_next      = cur_reg;
		cur_next.done = 1'b0;
		case (cur_reg.state)
			tsnw_pkg::TSNW_TX_IDLE: begin
				if (link.send_req) begin
					cur_next.state   = tsnw_pkg::TSNW_TX_WAIT;
					cur_next.wr_req  = 1'b1;
					cur_next.wr_data = link.send_word;
					cur_next.wr_area = link.send_area;
				end
			end
			tsnw_pkg::TSNW_TX_WAIT: begin
				if (wr_ack_i) begin
					cur_next.state  = tsnw_pkg::TSNW_TX_IDLE;
					cur_next.wr_req = 1'b0;
					cur_next.done   = 1'b1;
				end
			end
			default: begin
				cur_next.state  = tsnw_pkg::TSNW_TX_IDLE;
				cur_next.wr_req = 1'b0;
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign link.busy      = (cur_reg.state == tsnw_pkg::TSNW_TX_WAIT);
	assign link.done      = cur_reg.done;
	assign link.done_word = cur_reg.wr_data;
	assign link.wr_req    = cur_reg.wr_req;
	assign link.wr_area   = cur_reg.wr_area;
	assign wr_data_o      = cur_reg.wr_data;
endmodule // tsnw_report_tx
`default_nettype wire

//--- tsnw_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsnw_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tsnw_tb;
	logic        clk, rst_n, run, menu, pm, we, re, ack, req, rind, irq, bad;
	logic [2:0]  ev, e, wa, ma;
	logic [7:0]  addr;
	logic [31:0] wd, rd, q;
	logic [15:0] wdat, mw, mc, mcs;
	logic [1:0]  dly;
	int          errors, compares, i;

	tsnw_top dut_u (.clk_i(clk), .rst_n_i(rst_n), .mode_run_i(run),
		.sysmenu_shown_i(menu), .screen_changed_i(ev[2]), .value_stored_i(ev[1]),
		.pwd_attempt_i(ev[0]), .pwd_match_i(pm), .wr_req_o(req), .wr_data_o(wdat),
		.wr_area_o(wa), .wr_ack_i(ack), .run_ind_o(rind), .reg_addr_i(addr),
		.reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rd), .irq_o(irq));
	tsnw_ctrl_model mdl_u (.clk_i(clk), .rst_n_i(rst_n), .wr_req_i(req), .wr_data_i(wdat),
		.wr_area_i(wa), .dly_i(dly), .wr_ack_o(ack), .word_o(mw), .area_o(ma),
		.cnt_o(mc), .bad_o(bad));

	// Free-running bench clock.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Expected status word from the four reported states.
	function automatic logic [15:0] wexp(input logic r, s, v, p);
		wexp = {r, 2'b00, s, v, 1'b0, p, 9'h000};
	endfunction

	// Register port cycles, one strobe cycle each.
	task automatic rw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rr(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		#1 d = rd;
	endtask
	// One-cycle event pulse; the controller latency is redrawn each time.
	task automatic pulse(input logic [2:0] x, input logic m);
		@(posedge clk);
		ev <= x;
		pm <= m;
		dly <= 2'($urandom);
		@(posedge clk);
		ev <= 3'h0;
	endtask
	task automatic settle;
		@(posedge clk);
		#1;
	endtask
	// Waits, bounded, for the controller to hold the given word.
	task automatic expw(input logic [15:0] x);
		int n;
		n = 0;
		while (mw !== x && n < 60) begin
			@(posedge clk);
			n++;
		end
		`CHK(mw, x)
	endtask
	task automatic complete_run;
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		complete_run();
	end

	initial begin
		{rst_n, run, menu, pm, we, re, ev, addr, wd, dly} = '0;
		errors = 0;
		compares = 0;
		void'($urandom(32'hA500));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rw(`TSNW_OFS_STATUS_WORD, 32'hFFFFFFFF);
		rw(8'h14, 32'hFFFFFFFF);
		for (i = 0; i < 6; i++) begin
			rr(8'(4 * i), q);
			`CHK(q, (i == 1) ? 32'h1 : 32'h0)
		end
		@(posedge clk);
		run <= 1'b1;
		expw(16'h8000);
		`CHK(rind, 1'b1)
		$display("test reset and run done");
		for (i = 0; i < 30; i++) begin
			e = (i == 29) ? 3'b110 : (($urandom % 2) ? 3'b100 : 3'b010);
			pulse(e, 1'b0);
			expw(wexp(1'b1, e[2], e[1], 1'b0));
			expw(16'h8000);
		end
		$display("test events done");
		rw(`TSNW_OFS_IRQ_MASK, 32'h2);
		for (i = 0; i < 5; i++)
			pulse(3'b001, i == 2);
		rr(`TSNW_OFS_IRQ_STATUS, q);
		`CHK(q[1], 1'b0)
		pulse(3'b001, 1'b0);
		expw(16'h8200);
		expw(16'h8000);
		rr(`TSNW_OFS_IRQ_STATUS, q);
		`CHK({q[1], irq}, 2'b11)
		rw(`TSNW_OFS_IRQ_MASK, 32'h0);
		settle();
		`CHK(irq, 1'b0)
		rw(`TSNW_OFS_IRQ_MASK, 32'h2);
		settle();
		`CHK(irq, 1'b1)
		rw(`TSNW_OFS_IRQ_STATUS, 32'h2);
		settle();
		`CHK(irq, 1'b0)
		$display("test password done");
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			if (i == 0)
				menu <= 1'b1;
			else
				run <= 1'b0;
			expw(16'h0000);
			mcs = mc;
			pulse(3'b100, 1'b0);
			repeat (20) @(posedge clk);
			`CHK(mc, mcs)
			@(posedge clk);
			menu <= 1'b0;
			run <= 1'b1;
			expw(16'h9000);
			expw(16'h8000);
		end
		$display("test stop done");
		rw(`TSNW_OFS_CTRL, 32'h5);
		pulse(3'b010, 1'b0);
		expw(16'h8800);
		`CHK(ma, 3'h2)
		expw(16'h8000);
		// A disabled block holds its event until it is enabled again.
		rw(`TSNW_OFS_CTRL, 32'h0);
		mcs = mc;
		pulse(3'b010, 1'b0);
		repeat (12) @(posedge clk);
		`CHK(mc, mcs)
		rw(`TSNW_OFS_CTRL, 32'h1);
		expw(16'h8800);
		expw(16'h8000);
		rw(`TSNW_OFS_CTRL, 32'hB);
		rr(`TSNW_OFS_IRQ_STATUS, q);
		`CHK(q[2], 1'b1)
		rw(`TSNW_OFS_CTRL, 32'h1);
		rw(`TSNW_OFS_IRQ_STATUS, 32'h4);
		rr(`TSNW_OFS_IRQ_STATUS, q);
		`CHK(q[2], 1'b0)
		rr(`TSNW_OFS_REPORT_CNT, q);
		`CHK(q, {16'h0000, mc})
		rr(`TSNW_OFS_STATUS_WORD, q);
		`CHK(q, {16'h0000, mw})
		`CHK(bad, 1'b0)
		$display("test area done");
		complete_run();
	end
endmodule // tsnw_tb
`default_nettype wire

//--- tsnw_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsnw_regs.svh"
// Status notify word engine of an operator terminal.
// The terminal keeps a 16-bit word that tells the controller its run state and three
// events. Whenever that word changes while running, and once when the terminal stops, one write puts it into the controller's memory.
module tsnw_top (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Terminal state from the display core, same clock domain.
	input  wire logic        mode_run_i,
	input  wire logic        sysmenu_shown_i,
	input  wire logic        screen_changed_i,
	input  wire logic        value_stored_i,
	input  wire logic        pwd_attempt_i,
	input  wire logic        pwd_match_i,
	// Write port toward the controller memory.
	output logic             wr_req_o,
	output logic [15:0]      wr_data_o,
	output logic [2:0]       wr_area_o,
	input  wire logic        wr_ack_i,
	// Run indicator copy for the display core.
	output logic             run_ind_o,
	// Software register port.
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_we_i,
	input  wire logic        reg_re_i,
	output logic [31:0]      reg_rdata_o,
	output logic             irq_o
);
	tsnw_pkg::tsnw_top_reg_t cur_reg;
	tsnw_pkg::tsnw_top_reg_t cur_next;

	tsnw_link_if link ();

	// Password mismatch counter.
	tsnw_pwd_check u_pwd (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.link    (link.pwd)
	);

	// Controller write engine.
	tsnw_report_tx u_tx (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.wr_ack_i  (wr_ack_i),
		.wr_data_o (wr_data_o),
		.link      (link.tx)
	);

	// Helper values computed from the current state and inputs.
	logic        run_now;
	logic        area_ok;
	logic [15:0] word_now;
	logic        word_changed;
	logic        may_access;
	logic        send_now;
	logic [3:0]  irq_events;
	logic        wr_ctrl;
	logic        wr_irq_stat;
	logic        wr_irq_mask;
	logic [3:0]  w1c_mask;

	// The run indicator is a plain function of the mode and menu state.
	// Only normal running mode with no menu on the screen counts as running.
	always_comb begin
		run_now = mode_run_i & ~sysmenu_shown_i;
	end

	// Only the five word-addressable data areas may hold the status word.
	// A timer or counter area selection stops all writes and raises an error.
	always_comb begin
		area_ok = (cur_reg.area == tsnw_pkg::TSNW_AREA_DATA_MEMORY)
			| (cur_reg.area == tsnw_pkg::TSNW_AREA_INTERNAL_RELAY)
			| (cur_reg.area == tsnw_pkg::TSNW_AREA_HOLDING_RELAY)
			| (cur_reg.area == tsnw_pkg::TSNW_AREA_AUX_RELAY)
			| (cur_reg.area == tsnw_pkg::TSNW_AREA_LINK_RELAY);
	end

	// Assemble the word from its four live bits; every other position stays zero.
	always_comb begin
		word_now                     = 16'h0000;
		word_now[`TSNW_BIT_RUN]      = cur_reg.run_ind;
		word_now[`TSNW_BIT_SCREEN]   = cur_reg.scr_evt;
		word_now[`TSNW_BIT_VALUE]    = cur_reg.val_evt;
		word_now[`TSNW_BIT_PASSWORD] = cur_reg.pwd_evt;
	end

	// Decide whether a new write to the controller starts this cycle.
	// A write is started only on a change, never on a timer, so the controller
	// sees every edge of the word and no redundant traffic.
	// While stopped the memory is left alone; the one write that carries the falling
	// run bit is still allowed, since otherwise the controller could never see the stop.
	// Nothing starts in the cycle in which a report completes. The reported event bits
	// are still set in that cycle, and sending them would report the same event twice.
	always_comb begin
		word_changed = (word_now != cur_reg.last_word) | ~cur_reg.sent_once;
		may_access   = cur_reg.run_ind | cur_reg.last_word[`TSNW_BIT_RUN];
		send_now     = cur_reg.enable & area_ok & may_access & word_changed
			& ~link.busy & ~link.done & ~cur_reg.send_req;
	end

	// Register write decode; the bus never waits.
	always_comb begin
		wr_ctrl     = reg_we_i & (reg_addr_i == `TSNW_OFS_CTRL);
		wr_irq_stat = reg_we_i & (reg_addr_i == `TSNW_OFS_IRQ_STATUS);
		wr_irq_mask = reg_we_i & (reg_addr_i == `TSNW_OFS_IRQ_MASK);
		w1c_mask    = wr_irq_stat ? reg_wdata_i[3:0] : 4'h0;
	end

	// Interrupt sources, each a one-cycle cause except the area error.
	// The area error is a level, so its sticky bit comes straight back after a clear
	// until software picks a legal area or turns the block off.
	always_comb begin
		irq_events                       = 4'h0;
		irq_events[`TSNW_IRQ_REPORTED]   = link.done;
		irq_events[`TSNW_IRQ_PWD_FAIL]   = link.pwd_fail;
		irq_events[`TSNW_IRQ_AREA_ERR]   = cur_reg.enable & ~area_ok;
		irq_events[`TSNW_IRQ_RUN_CHANGE] = run_now ^ cur_reg.run_ind;
	end

	// Next-state logic for the whole top state.
	always_comb begin
		cur_next          = cur_reg;
		cur_next.send_req = 1'b0;
		cur_next.run_ind  = run_now;

		// Reported event bits are cleared first, so that a new event in the same
		// cycle wins and is reported by the next write instead of being lost.
		if (link.done) begin
			if (link.done_word[`TSNW_BIT_SCREEN]) begin
				cur_next.scr_evt = 1'b0;
			end
			if (link.done_word[`TSNW_BIT_VALUE]) begin
				cur_next.val_evt = 1'b0;
			end
			if (link.done_word[`TSNW_BIT_PASSWORD]) begin
				cur_next.pwd_evt = 1'b0;
			end
			cur_next.report_cnt = cur_reg.report_cnt + 16'h0001;
		end

		// Event capture; any screen switch source arrives on the same strobe.
		if (screen_changed_i) begin
			cur_next.scr_evt = 1'b1;
		end
		if (value_stored_i) begin
			cur_next.val_evt = 1'b1;
		end
		if (link.pwd_fail) begin
			cur_next.pwd_evt = 1'b1;
		end

		// Launch a write and remember what was sent, so later changes are seen.
		if (send_now) begin
			cur_next.send_req  = 1'b1;
			cur_next.last_word = word_now;
			cur_next.sent_once = 1'b1;
		end

		// Control register: enable and destination area.
		if (wr_ctrl) begin
			cur_next.enable = reg_wdata_i[`TSNW_CTRL_ENABLE];
			cur_next.area   = tsnw_pkg::tsnw_area_t'(
				reg_wdata_i[`TSNW_CTRL_AREA_MSB:`TSNW_CTRL_AREA_LSB]);
		end

		// Sticky status: write one to clear, but a same-cycle event keeps its bit.
		cur_next.irq_stat = (cur_reg.irq_stat & ~w1c_mask) | irq_events;
		if (wr_irq_mask) begin
			cur_next.irq_mask = reg_wdata_i[3:0];
		end
		cur_next.irq = |(cur_next.irq_stat & cur_next.irq_mask);

		// Read data appear in the cycle after the strobe and only there.
		cur_next.rd_data = 32'h0000_0000;
		if (reg_re_i) begin
			case (reg_addr_i)
				`TSNW_OFS_STATUS_WORD: begin
					cur_next.rd_data = {16'h0000, cur_reg.last_word};
				end
				`TSNW_OFS_CTRL: begin
					cur_next.rd_data = {28'h0000000, cur_reg.area, cur_reg.enable};
				end
				`TSNW_OFS_IRQ_STATUS: begin
					cur_next.rd_data = {28'h0000000, cur_reg.irq_stat};
				end
				`TSNW_OFS_IRQ_MASK: begin
					cur_next.rd_data = {28'h0000000, cur_reg.irq_mask};
				end
				`TSNW_OFS_REPORT_CNT: begin
					cur_next.rd_data = {16'h0000, cur_reg.report_cnt};
				end
				default: begin
					cur_next.rd_data = 32'h0000_0000;
				end
			endcase
		end
	end

	// State register; reset leaves the block enabled toward the data memory area.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cur_reg          <= '0;
			cur_reg.enable   <= `TSNW_RST_ENABLE;
			cur_reg.area     <= tsnw_pkg::TSNW_AREA_DATA_MEMORY;
			cur_reg.irq_mask <= `TSNW_RST_IRQ_MASK;
		end else begin
			cur_reg <= cur_next;
		end
	end

	// Connections to the helpers.
	// The password counter is reset while stopped, so a run of misses never
	// spans a stop and a restart.
	assign link.send_req    = cur_reg.send_req;
	assign link.send_word   = cur_reg.last_word;
	assign link.send_area   = cur_reg.area;
	assign link.pwd_attempt = pwd_attempt_i;
	assign link.pwd_match   = pwd_match_i;
	assign link.pwd_reset   = ~cur_reg.run_ind;

	// All outputs come straight from flip-flops here or in the write engine.
	assign wr_req_o    = link.wr_req;
	assign wr_area_o   = link.wr_area;
	assign run_ind_o   = cur_reg.run_ind;
	assign reg_rdata_o = cur_reg.rd_data;
	assign irq_o       = cur_reg.irq;
endmodule // tsnw_top
`default_nettype wire
